// *** cbsm_regs.svh ***
// Register indices, field positions, reset values and counts of the clock-buffer configuration port.
// Included by the design files; holds definitions only.
`ifndef CBSM_REGS_SVH
`define CBSM_REGS_SVH

// Register indices as sent in the index byte.
`define CBSM_IDX_OUT_EN 8'h00
`define CBSM_IDX_PLL_AMP 8'h01
`define CBSM_IDX_SLEW 8'h02
`define CBSM_IDX_FREQ 8'h03
`define CBSM_IDX_STOP 8'h0b

// Reset values; reserved bits hold these for good, except bits 7:6 of the stop register, which take writes.
`define CBSM_OUT_EN_RST 8'h5a
`define CBSM_PLL_AMP_RST 8'h06
`define CBSM_SLEW_RST 8'hff
`define CBSM_FREQ_RST 8'hc7
`define CBSM_STOP_RST 8'h40

// Bits that software may change.
`define CBSM_OUT_EN_WMASK 8'h5a
`define CBSM_PLL_AMP_WMASK 8'h3b
`define CBSM_SLEW_WMASK 8'h5a
`define CBSM_FREQ_WMASK 8'h39
`define CBSM_STOP_WMASK 8'hc3

// Per-output bit positions in the enable and slew registers.
`define CBSM_OUT0_BIT 1
`define CBSM_OUT1_BIT 3
`define CBSM_OUT2_BIT 4
`define CBSM_OUT3_BIT 6

// Fields of the mode/amplitude, frequency and stop registers.
`define CBSM_PLL_RB_HI 7
`define CBSM_PLL_RB_LO 6
`define CBSM_PLL_SW_OVR_BIT 5
`define CBSM_PLL_SW_HI 4
`define CBSM_PLL_SW_LO 3
`define CBSM_AMP_HI 1
`define CBSM_AMP_LO 0
`define CBSM_FREQ_EN_BIT 5
`define CBSM_FREQ_HI 4
`define CBSM_FREQ_LO 3
`define CBSM_FB_EDGE_BIT 0
`define CBSM_STOP_HI 1
`define CBSM_STOP_LO 0

// Fixed upper address nibble, byte count returned on reads, strap settling delay.
`define CBSM_ADDR_HI 4'hd
`define CBSM_RD_COUNT 8'h04
`define CBSM_STRAP_WAIT 3'h4

`endif

// *** cbsm_pkg.sv ***
// Types shared by the clock-buffer configuration port.
// Assumes nothing of its surroundings.
package cbsm_pkg;

  typedef enum logic [2:0] {
    CBSM_ST_IDLE = 3'b000,
    CBSM_ST_ADDR = 3'b001,
    CBSM_ST_CMD = 3'b010,
    CBSM_ST_COUNT = 3'b011,
    CBSM_ST_WDATA = 3'b100,
    CBSM_ST_RCOUNT = 3'b101,
    CBSM_ST_RDATA = 3'b110,
    CBSM_ST_IGNORE = 3'b111
  } cbsm_state_t;

  typedef enum logic [1:0] {
    CBSM_STOP_LOW_LOW = 2'b00,
    CBSM_STOP_HIZ = 2'b01,
    CBSM_STOP_TRUE_HI = 2'b10,
    CBSM_STOP_TRUE_LO = 2'b11
  } cbsm_stop_t;

endpackage

// *** cbsm_pin_sync.sv ***
// Three-stage synchroniser for pins; a new level is taken once stages two and three agree.
// Assumes the pins are asynchronous to mclk.
`timescale 1ns/10ps
module cbsm_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Raw pins and filtered levels.
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  import cbsm_pkg::*;

  if (WIDTH < 1) begin : g_chk
    $error("cbsm_pin_sync needs WIDTH of at least one");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_q <= RST_VAL;
        s2_q <= RST_VAL;
        s3_q <= RST_VAL;
        level[i] <= RST_VAL;
      end else begin
        s1_q <= pin[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          level[i] <= s3_q;
        end
      end
    end
  end
endmodule

// *** cbsm_out_ctrl.sv ***
// Per-output gating: software enable, enable pin and the selected disable state.
// Assumes enables and stop state are already in the mclk domain.
`timescale 1ns/10ps
module cbsm_out_ctrl #(
  parameter int NUM_OUT = 4
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Controls.
  input wire logic [NUM_OUT-1:0] sw_enable,
  input wire logic [NUM_OUT-1:0] pin_enable,
  input wire cbsm_pkg::cbsm_stop_t stop_state,
  // Output pair states.
  output logic [NUM_OUT-1:0] out_run,
  output logic [NUM_OUT-1:0] out_true,
  output logic [NUM_OUT-1:0] out_comp,
  output logic [NUM_OUT-1:0] out_hiz
);
  import cbsm_pkg::*;

  if (NUM_OUT < 1) begin : g_chk
    $error("cbsm_out_ctrl needs at least one output");
  end

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    always_ff @(posedge mclk) begin
      if (rst) begin
        out_run[i] <= 1'b0;
        out_true[i] <= 1'b0;
        out_comp[i] <= 1'b0;
        out_hiz[i] <= 1'b0;
      end else if (sw_enable[i] && pin_enable[i]) begin // R19
        out_run[i] <= 1'b1;
        out_true[i] <= 1'b0;
        out_comp[i] <= 1'b0;
        out_hiz[i] <= 1'b0;
      end else begin // R8
        out_run[i] <= 1'b0;
        case (stop_state) // R9
          CBSM_STOP_HIZ: begin
            out_true[i] <= 1'b0;
            out_comp[i] <= 1'b0;
            out_hiz[i] <= 1'b1;
          end
          CBSM_STOP_TRUE_HI: begin
            out_true[i] <= 1'b1;
            out_comp[i] <= 1'b0;
            out_hiz[i] <= 1'b0;
          end
          CBSM_STOP_TRUE_LO: begin
            out_true[i] <= 1'b0;
            out_comp[i] <= 1'b1;
            out_hiz[i] <= 1'b0;
          end
          default: begin
            out_true[i] <= 1'b0;
            out_comp[i] <= 1'b0;
            out_hiz[i] <= 1'b0;
          end
        endcase
      end
    end

    sw_off_a: assert property (@(posedge mclk) disable iff (rst) !sw_enable[i] |=> !out_run[i]) // R8
      else $error("output runs while its software enable is clear");
  end
endmodule

// *** cbsm_smbus_regs.sv ***
// SMBus slave and control registers of a four-output clock buffer.
// Assumes SCL and SDA arrive as pins, SDA open drain resolved outside; straps static around reset.
// Notes on behaviour
// R1: Slave only; one 7-bit address plus direction bit; block write and block read.
// R2: A stop after any whole byte ends the transfer; finished bytes are kept.
// R3: Address upper nibble is 1101; low three bits come from the strap latched at power-up.
// R4: Write: address, index N, count X, X data bytes; every byte acknowledged.
// R5: Read: index written, repeated start, read address; returns count then data from N.
// R6: Host acknowledges each read byte except the last, which it refuses before stop.
// R7: Register 0 enable bits at 6,4,3,1 reset to one; one hands control to the pin.
// R8: A cleared enable bit ignores the pin and forces the selected disable state.
// R9: Stop-state codes: 00 low/low, 01 high-Z, 10 true high, 11 true low; reset 00.
// R10: Register 1 bits 7:6 read the latched mode strap; writes there do nothing.
// R11: Register 1 bit 5 picks strap mode (0) or software mode (1); resets to 0.
// R12: Software mode bits 4:3 reset to 00 and act only when bit 5 is one.
// R13: Register 1 bits 1:0 set swing 0.6/0.68/0.75/0.85 V; reset 10.
// R14: Register 2 slew bits at 6,4,3,1: 0 slow, 1 fast; reset to one.
// R15: Register 3 bit 5 enables software frequency code in bits 4:3; both reset zero.
// R16: The frequency code has no effect unless register 3 bit 5 is one.
// R17: Register 3 bit 0 sets feedback clock slew: 0 slow, 1 fast; reset one.
// R18: Reserved bits ignore writes and read back their power-up values; stop register bits 7:6 take writes here.
// R19: With the enable bit set, an output runs only while its pin is asserted.
// R20: The register index steps by one after each data byte.
`timescale 1ns/10ps
`include "cbsm_regs.svh"
module cbsm_smbus_regs (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // SMBus pins.
  input wire logic scl_pin,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and output enable pins.
  input wire logic [2:0] address_strap_pin,
  input wire logic [1:0] loop_bandwidth_strap,
  input wire logic [3:0] oe_pin_n,
  // Output pair control.
  output logic [3:0] out_run,
  output logic [3:0] out_true,
  output logic [3:0] out_comp,
  output logic [3:0] out_hiz,
  // Analog settings.
  output logic [3:0] out_edge_speed,
  output logic feedback_edge_speed,
  output logic [1:0] amplitude,
  output logic [1:0] pll_mode,
  output logic freq_sw_en,
  output logic [1:0] freq_code
);
  import cbsm_pkg::*;

  logic scl_s;
  logic sda_s;
  logic [2:0] addr_strap_s;
  logic [1:0] bw_strap_s;
  logic [3:0] oe_n_s;
  logic scl_p_q;
  logic sda_p_q;
  logic [2:0] strap_wait_q;
  logic strap_done_q;
  logic [2:0] addr_strap_q;
  logic [1:0] pll_strap_q;
  cbsm_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] idx_q;
  logic [7:0] rem_q;
  logic sda_oe_q;
  logic nack_q;
  logic [7:0] out_en_q;
  logic [7:0] pll_amp_q;
  logic [7:0] slew_q;
  logic [7:0] freq_q;
  logic [7:0] stop_q;
  logic [1:0] pll_mode_q;
  logic freq_sw_en_q;
  logic [1:0] freq_code_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_match;
  logic is_tx;
  logic wr_fire;
  logic [3:0] sw_en;
  logic [7:0] rd_data;

  cbsm_pin_sync #(.WIDTH(2), .RST_VAL(1'b1)) u_bus_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({scl_pin, sda_i}),
    .level({scl_s, sda_s})
  );

  cbsm_pin_sync #(.WIDTH(9), .RST_VAL(1'b0)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({address_strap_pin, loop_bandwidth_strap, ~oe_pin_n}),
    .level({addr_strap_s, bw_strap_s, oe_n_s})
  );

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign addr_match = (shift_q[7:4] == `CBSM_ADDR_HI) && (shift_q[3:1] == addr_strap_q); // R3
  assign is_tx = (st_q == CBSM_ST_RCOUNT) || (st_q == CBSM_ST_RDATA);
  assign wr_fire = scl_fall && (cnt_q == 4'h7) && (st_q == CBSM_ST_WDATA) && (rem_q != 8'h00);

  // Read view; unmapped indices read zero.
  always_comb begin
    case (idx_q)
      `CBSM_IDX_OUT_EN: rd_data = out_en_q;
      `CBSM_IDX_PLL_AMP: rd_data = {pll_strap_q, pll_amp_q[5:0]}; // R10
      `CBSM_IDX_SLEW: rd_data = slew_q;
      `CBSM_IDX_FREQ: rd_data = freq_q;
      `CBSM_IDX_STOP: rd_data = stop_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Straps are caught once, a few cycles after reset release, once the synchroniser is filled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_wait_q <= 3'h0;
      strap_done_q <= 1'b0;
      addr_strap_q <= 3'h0;
      pll_strap_q <= 2'h0;
    end else if (!strap_done_q) begin
      if (strap_wait_q == `CBSM_STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        addr_strap_q <= addr_strap_s; // R3
        pll_strap_q <= bw_strap_s; // R10
      end else begin
        strap_wait_q <= strap_wait_q + 3'h1;
      end
    end
  end

  // Bus engine: bits sampled on SCL rise, SDA changed on SCL fall.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= CBSM_ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      idx_q <= 8'h00;
      rem_q <= 8'h00;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (stop_ev) begin // R2
      st_q <= CBSM_ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin // R1
      st_q <= CBSM_ST_ADDR;
      // The SCL fall that follows a start carries no bit, so the count wraps to zero on it.
      cnt_q <= 4'hf;
      sda_oe_q <= 1'b0;
    end else if (st_q != CBSM_ST_IDLE) begin
      if (scl_rise) begin
        if (cnt_q < 4'h8 && !is_tx) begin
          shift_q <= {shift_q[6:0], sda_s};
        end
        if (cnt_q == 4'h8) begin
          nack_q <= sda_s; // R6
        end
      end else if (scl_fall) begin
        if (cnt_q == 4'h8) begin
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        if (cnt_q == 4'h7) begin
          if (is_tx) begin
            sda_oe_q <= 1'b0;
          end else if (st_q == CBSM_ST_ADDR) begin
            sda_oe_q <= addr_match; // R1
          end else begin
            sda_oe_q <= (st_q != CBSM_ST_IGNORE); // R4
          end
          if (wr_fire) begin
            idx_q <= idx_q + 8'h01; // R20
            rem_q <= rem_q - 8'h01;
          end
        end else if (cnt_q == 4'h8) begin
          sda_oe_q <= 1'b0;
          case (st_q)
            CBSM_ST_ADDR: begin
              if (!addr_match) begin
                st_q <= CBSM_ST_IGNORE;
              end else if (!shift_q[0]) begin
                st_q <= CBSM_ST_CMD;
              end else begin // R5
                st_q <= CBSM_ST_RCOUNT;
                shift_q <= `CBSM_RD_COUNT;
                sda_oe_q <= (`CBSM_RD_COUNT < 8'h80);
              end
            end
            CBSM_ST_CMD: begin
              idx_q <= shift_q;
              st_q <= CBSM_ST_COUNT;
            end
            CBSM_ST_COUNT: begin // R4
              rem_q <= shift_q;
              st_q <= CBSM_ST_WDATA;
            end
            CBSM_ST_RCOUNT, CBSM_ST_RDATA: begin
              if (nack_q) begin // R6
                st_q <= CBSM_ST_IGNORE;
              end else begin
                st_q <= CBSM_ST_RDATA;
                shift_q <= rd_data; // R5
                sda_oe_q <= !rd_data[7];
                idx_q <= idx_q + 8'h01; // R20
              end
            end
            default: begin
              st_q <= st_q;
            end
          endcase
        end else if (is_tx) begin
          sda_oe_q <= !shift_q[6];
          shift_q <= {shift_q[6:0], 1'b0};
        end else begin
          sda_oe_q <= 1'b0;
        end
      end
    end
  end

  // Register writes keep reserved and read-only bits as they are, except stop register bits 7:6, which are written.
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_en_q <= `CBSM_OUT_EN_RST; // R7
      pll_amp_q <= `CBSM_PLL_AMP_RST; // R13
      slew_q <= `CBSM_SLEW_RST; // R14
      freq_q <= `CBSM_FREQ_RST; // R15
      stop_q <= `CBSM_STOP_RST; // R9
    end else if (wr_fire) begin // R2
      case (idx_q) // R18
        `CBSM_IDX_OUT_EN: out_en_q <= (out_en_q & ~`CBSM_OUT_EN_WMASK) | (shift_q & `CBSM_OUT_EN_WMASK);
        `CBSM_IDX_PLL_AMP: pll_amp_q <= (pll_amp_q & ~`CBSM_PLL_AMP_WMASK) | (shift_q & `CBSM_PLL_AMP_WMASK);
        `CBSM_IDX_SLEW: slew_q <= (slew_q & ~`CBSM_SLEW_WMASK) | (shift_q & `CBSM_SLEW_WMASK);
        `CBSM_IDX_FREQ: freq_q <= (freq_q & ~`CBSM_FREQ_WMASK) | (shift_q & `CBSM_FREQ_WMASK);
        `CBSM_IDX_STOP: stop_q <= (stop_q & ~`CBSM_STOP_WMASK) | (shift_q & `CBSM_STOP_WMASK);
        default: stop_q <= stop_q;
      endcase
    end
  end

  // Effective mode and frequency settings.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_mode_q <= 2'h0;
      freq_sw_en_q <= 1'b0;
      freq_code_q <= 2'h0;
    end else begin
      if (pll_amp_q[`CBSM_PLL_SW_OVR_BIT]) begin // R11
        pll_mode_q <= pll_amp_q[`CBSM_PLL_SW_HI:`CBSM_PLL_SW_LO]; // R12
      end else begin
        pll_mode_q <= pll_strap_q;
      end
      freq_sw_en_q <= freq_q[`CBSM_FREQ_EN_BIT]; // R15
      freq_code_q <= freq_q[`CBSM_FREQ_EN_BIT] ? freq_q[`CBSM_FREQ_HI:`CBSM_FREQ_LO] : 2'h0; // R16
    end
  end

  assign sw_en = {out_en_q[`CBSM_OUT3_BIT], out_en_q[`CBSM_OUT2_BIT], out_en_q[`CBSM_OUT1_BIT],
                  out_en_q[`CBSM_OUT0_BIT]}; // R7

  cbsm_out_ctrl #(.NUM_OUT(4)) u_out (
    .mclk(mclk),
    .rst(rst),
    .sw_enable(sw_en),
    .pin_enable(oe_n_s),
    .stop_state(cbsm_stop_t'(stop_q[`CBSM_STOP_HI:`CBSM_STOP_LO])), // R8
    .out_run(out_run),
    .out_true(out_true),
    .out_comp(out_comp),
    .out_hiz(out_hiz)
  );

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign out_edge_speed = {slew_q[`CBSM_OUT3_BIT], slew_q[`CBSM_OUT2_BIT], slew_q[`CBSM_OUT1_BIT],
                           slew_q[`CBSM_OUT0_BIT]}; // R14
  assign feedback_edge_speed = freq_q[`CBSM_FB_EDGE_BIT]; // R17
  assign amplitude = pll_amp_q[`CBSM_AMP_HI:`CBSM_AMP_LO]; // R13
  assign pll_mode = pll_mode_q;
  assign freq_sw_en = freq_sw_en_q;
  assign freq_code = freq_code_q;

  addr_nack_a: assert property (@(posedge mclk) disable iff (rst) // R3
    (st_q == CBSM_ST_ADDR && scl_fall && cnt_q == 4'h7 && shift_q[7:4] != `CBSM_ADDR_HI) |=> !sda_oe_q)
    else $error("foreign address acknowledged");
  data_ack_a: assert property (@(posedge mclk) disable iff (rst) // R4
    (st_q == CBSM_ST_WDATA && scl_fall && cnt_q == 4'h7 && !stop_ev && !start_ev) |=> sda_oe_q)
    else $error("write byte not acknowledged");
  index_step_a: assert property (@(posedge mclk) disable iff (rst) // R20
    wr_fire && !stop_ev && !start_ev |=> idx_q == $past(idx_q) + 8'h01)
    else $error("index did not step after a written byte");
  stop_keeps_a: assert property (@(posedge mclk) disable iff (rst) // R2
    stop_ev |=> st_q == CBSM_ST_IDLE && !sda_oe_q && $stable(out_en_q) && $stable(freq_q))
    else $error("stop did not end the transfer cleanly");
  strap_hold_a: assert property (@(posedge mclk) disable iff (rst) // R10
    strap_done_q && $past(strap_done_q) |-> $stable(pll_strap_q) && $stable(addr_strap_q))
    else $error("strap value changed after capture");
  mode_source_a: assert property (@(posedge mclk) disable iff (rst) // R11
    ##1 pll_mode_q == ($past(pll_amp_q[5]) ? $past(pll_amp_q[4:3]) : $past(pll_strap_q)))
    else $error("PLL mode taken from the wrong source");
  freq_gate_a: assert property (@(posedge mclk) disable iff (rst) // R16
    !freq_sw_en_q |-> freq_code_q == 2'h0)
    else $error("frequency code active while disabled");
  read_nack_a: assert property (@(posedge mclk) disable iff (rst) // R6
    (is_tx && scl_fall && cnt_q == 4'h8 && nack_q && !stop_ev && !start_ev) |=> st_q == CBSM_ST_IGNORE && !sda_oe_q)
    else $error("read continued after host refusal");
  reserved_keep_a: assert property (@(posedge mclk) disable iff (rst) // R18
    out_en_q[7] == 1'b0 && out_en_q[0] == 1'b0 && pll_amp_q[2] && freq_q[7:6] == 2'h3 && slew_q[0])
    else $error("reserved bit changed");
  enable_reset_a: assert property (@(posedge mclk) rst |=> out_en_q == `CBSM_OUT_EN_RST) // R7
    else $error("enable register reset value wrong");

  write_seen_c: cover property (@(posedge mclk) disable iff (rst) wr_fire ##[1:400] stop_ev);
  read_seen_c: cover property (@(posedge mclk) disable iff (rst)
    st_q == CBSM_ST_RCOUNT ##[1:400] st_q == CBSM_ST_RDATA);
  nack_end_c: cover property (@(posedge mclk) disable iff (rst)
    st_q == CBSM_ST_RDATA ##[1:400] st_q == CBSM_ST_IGNORE);
  foreign_c: cover property (@(posedge mclk) disable iff (rst) st_q == CBSM_ST_ADDR ##1 st_q == CBSM_ST_IGNORE);
endmodule

// *** cbsm_host_model.sv ***
// SMBus host model that runs block writes and block reads against the configuration port.
// Assumes pull-ups on SCL and SDA; the bench calls its tasks by hierarchical name.
`timescale 1ns/10ps
module cbsm_host_model (
  // Clock.
  input wire logic mclk,
  // Bus lines.
  input wire logic dev_sda_oe,
  output logic scl_pin,
  output logic sda_line
);
  logic drv_low;

  // A released SDA line rises to the pull-up level.
  assign sda_line = !(drv_low || dev_sda_oe);

  initial begin
    scl_pin = 1'b1;
    drv_low = 1'b0;
  end

  task automatic w();
    repeat (12) @(posedge mclk);
    #1;
  endtask

  // Start or repeated start; SCL may be high or low on entry.
  task automatic start_c();
    drv_low = 1'b0;
    w();
    scl_pin = 1'b1;
    w();
    drv_low = 1'b1;
    w();
    scl_pin = 1'b0;
    w();
  endtask

  task automatic stop_c();
    drv_low = 1'b1;
    w();
    scl_pin = 1'b1;
    w();
    drv_low = 1'b0;
    w();
  endtask

  task automatic put_bit(input logic b, output logic r);
    drv_low = !b;
    w();
    scl_pin = 1'b1;
    w();
    r = sda_line;
    scl_pin = 1'b0;
    w();
  endtask

  // Sends a byte MSB first and clears ok when the device does not pull SDA low.
  task automatic tx(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ok = ok & !r;
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(last, r);
  endtask

  task automatic blk_write(input logic [6:0] a, input logic [7:0] n, x, input logic [31:0] d, input int nb,
                           output logic ok);
    ok = 1'b1;
    start_c();
    tx({a, 1'b0}, ok);
    tx(n, ok);
    tx(x, ok);
    for (int k = 0; k < nb; k++) begin
      tx(d[31 - 8 * k -: 8], ok);
    end
    stop_c();
  endtask

  task automatic blk_read(input logic [6:0] a, input logic [7:0] n, input int nb, output logic [7:0] x,
                          output logic [31:0] d, output logic ok);
    logic [7:0] b;
    ok = 1'b1;
    d = '0;
    start_c();
    tx({a, 1'b0}, ok);
    tx(n, ok);
    start_c();
    tx({a, 1'b1}, ok);
    rx(1'b0, x);
    for (int k = 0; k < nb; k++) begin
      rx(k == nb - 1, b);
      d[31 - 8 * k -: 8] = b;
    end
    stop_c();
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the clock-buffer configuration port.
// Assumes the host model is compiled first; straps stay fixed for the whole run.
`timescale 1ns/10ps
module tb;
  localparam logic [6:0] DEV = 7'h6d;
  localparam int LIMIT = 90000;
  logic mclk, rst, scl_pin, sda_i, sda_o, sda_oe, feedback_edge_speed, freq_sw_en, ok;
  logic [2:0] address_strap_pin;
  logic [1:0] loop_bandwidth_strap, amplitude, pll_mode, freq_code;
  logic [3:0] oe_pin_n, out_run, out_true, out_comp, out_hiz, out_edge_speed;
  logic [7:0] cnt;
  logic [31:0] dat;
  int n_fail, n_tests, cyc;

  cbsm_smbus_regs cbsm_smbus_regs_i (.mclk(mclk), .rst(rst), .scl_pin(scl_pin), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_strap_pin(address_strap_pin), .loop_bandwidth_strap(loop_bandwidth_strap),
    .oe_pin_n(oe_pin_n), .out_run(out_run), .out_true(out_true), .out_comp(out_comp), .out_hiz(out_hiz),
    .out_edge_speed(out_edge_speed), .feedback_edge_speed(feedback_edge_speed), .amplitude(amplitude),
    .pll_mode(pll_mode), .freq_sw_en(freq_sw_en), .freq_code(freq_code));

  cbsm_host_model cbsm_host_model_i (.mclk(mclk), .dev_sda_oe(sda_oe), .scl_pin(scl_pin), .sda_line(sda_i));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] n, x, input logic [31:0] d, input int nb);
    cbsm_host_model_i.blk_write(DEV, n, x, d, nb, ok);
    chk("write_ack", 8'(ok), 8'h01);
  endtask

  task automatic rd(input logic [7:0] n, input int nb);
    cbsm_host_model_i.blk_read(DEV, n, nb, cnt, dat, ok);
    chk("read_ack", 8'(ok), 8'h01);
    chk("read_count", cnt, 8'h04);
  endtask

  task automatic t_reset();
    rd(8'h00, 4);
    chk("reg0", dat[31:24], 8'h5a);
    chk("reg1", dat[23:16], 8'h86);
    chk("reg2", dat[15:8], 8'hff);
    chk("reg3", dat[7:0], 8'hc7);
    chk("edge", 8'(out_edge_speed), 8'h0f);
    chk("fb_edge", 8'(feedback_edge_speed), 8'h01);
    chk("amp", 8'(amplitude), 8'h02);
    chk("pll", 8'(pll_mode), 8'h02);
    chk("freq", {5'h0, freq_sw_en, freq_code}, 8'h00);
    chk("run", 8'(out_run), 8'h0f);
    chk("sda_o", 8'(sda_o), 8'h00);
  endtask

  task automatic t_zero();
    wr(8'h00, 8'h04, 32'h0, 4);
    rd(8'h00, 4);
    chk("reg0", dat[31:24], 8'h00);
    chk("reg1", dat[23:16], 8'h84);
    chk("reg2", dat[15:8], 8'ha5);
    chk("reg3", dat[7:0], 8'hc6);
    chk("edge", 8'(out_edge_speed), 8'h00);
    chk("fb_edge", 8'(feedback_edge_speed), 8'h00);
    chk("off", {out_run, out_true}, 8'h00);
    chk("off_b", {out_comp, out_hiz}, 8'h00);
  endtask

  task automatic t_modes();
    for (int a = 0; a < 4; a++) begin
      wr(8'h01, 8'h01, {6'h06, a[1:0], 24'h0}, 1);
      chk("amp", 8'(amplitude), 8'(a));
      chk("pll_strap", 8'(pll_mode), 8'h02);
    end
    wr(8'h01, 8'h01, 32'h38000000, 1);
    chk("pll_sw", 8'(pll_mode), 8'h03);
    wr(8'h03, 8'h01, 32'h18000000, 1);
    chk("freq_off", {5'h0, freq_sw_en, freq_code}, 8'h00);
    wr(8'h03, 8'h01, 32'h39000000, 1);
    chk("freq_on", {5'h0, freq_sw_en, freq_code}, 8'h07);
    chk("fb_edge", 8'(feedback_edge_speed), 8'h01);
  endtask

  task automatic t_stop();
    wr(8'h00, 8'h01, 32'h58000000, 1);
    @(posedge mclk);
    #1;
    oe_pin_n = 4'b0010;
    for (int s = 0; s < 4; s++) begin
      wr(8'h0b, 8'h01, {6'h10, s[1:0], 24'h0}, 1);
      chk("run", 8'(out_run), 8'h0c);
      chk("true", 8'(out_true), (s == 2) ? 8'h03 : 8'h00);
      chk("comp", 8'(out_comp), (s == 3) ? 8'h03 : 8'h00);
      chk("hiz", 8'(out_hiz), (s == 1) ? 8'h03 : 8'h00);
    end
    @(posedge mclk);
    #1;
    oe_pin_n = 4'h0;
  endtask

  task automatic t_early();
    wr(8'h01, 8'h03, 32'h1bff0000, 2);
    wr(8'h02, 8'h01, 32'h0, 2);
    rd(8'h01, 3);
    chk("reg1", dat[31:24], 8'h9f);
    chk("reg2", dat[23:16], 8'ha5);
    chk("reg3", dat[15:8], 8'hff);
  endtask

  task automatic t_addr();
    for (int k = 0; k < 2; k++) begin
      cbsm_host_model_i.blk_write((k == 0) ? 7'h6c : 7'h2d, 8'h00, 8'h01, 32'h0, 1, ok);
      chk("bad_addr_ack", 8'(ok), 8'h00);
    end
    rd(8'h00, 1);
    chk("reg0_kept", dat[31:24], 8'h58);
    chk("run", 8'(out_run), 8'h0e);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    address_strap_pin = 3'h5;
    loop_bandwidth_strap = 2'h2;
    oe_pin_n = 4'h0;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    t_reset();
    t_zero();
    t_modes();
    t_stop();
    t_early();
    t_addr();
    close_out();
  end
endmodule
